//--- inc/fe_ctrl_pkg.sv
// Purpose: Shared constants and types of the front end control registers.
// Assumes: Serial-bus subaddresses 00h to 02h, 8-bit registers.
// Notes:   Holds offsets, field positions, reset values and codes.
`default_nettype none

package fe_ctrl_pkg;

  // ********************************************************************
  // Serial bus
  // ********************************************************************
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h21;
  localparam logic       RW_READ          = 1'b1;
  localparam logic [2:0] LAST_BIT         = 3'h7;

  // ********************************************************************
  // Subaddresses
  // ********************************************************************
  localparam logic [7:0] SUB_SILICON_VERSION = 8'h00;
  localparam logic [7:0] SUB_GAIN_DELAY      = 8'h01;
  localparam logic [7:0] SUB_INPUT_SELECT    = 8'h02;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int VERSION_LSB = 4;
  localparam int VERSION_MSB = 7;
  localparam int WPD_BIT     = 6;
  localparam int HYST_LSB    = 4;
  localparam int HYST_MSB    = 5;
  localparam int DELAY_LSB   = 0;
  localparam int DELAY_MSB   = 3;
  localparam int FSEL_LSB    = 6;
  localparam int FSEL_MSB    = 7;
  localparam int MODE_LSB    = 0;
  localparam int MODE_MSB    = 5;

  // ********************************************************************
  // Reset values and masks
  // ********************************************************************
  // Arbitrary version value, not tied to any real part
  localparam logic [3:0] SILICON_VERSION_DEFAULT = 4'h1;
  localparam logic [7:0] GAIN_DELAY_RESET        = 8'h07;
  localparam logic [7:0] GAIN_DELAY_MASK         = 8'h7f;
  localparam logic [7:0] INPUT_SELECT_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ           = 8'h00;

  // ********************************************************************
  // Codes
  // ********************************************************************
  localparam logic [3:0] DELAY_NO_UPDATE = 4'hf;
  localparam logic [3:0] DELAY_MIN_CODE  = 4'he;
  localparam logic [1:0] FSEL_AMP_ONLY   = 2'h2;
  localparam logic [1:0] FSEL_AMP_FILTER = 2'h3;
  localparam logic [5:0] MODE_CVBS_IN11  = 6'h00;
  localparam logic [5:0] MODE_CVBS_IN12  = 6'h01;
  localparam logic [5:0] MODE_CVBS_IN21  = 6'h02;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_SUB,
    ST_SUB_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } bus_state_t;

endpackage

`default_nettype wire

//--- src/fe_ctrl_regfile.sv
// Purpose: Storage of the two writable and read-back of the three front end control registers.
// Assumes: One write strobe per received byte, address stable with it.
// Notes:   Read data is registered and follows the address one cycle late.
`timescale 1ns/1ps
`default_nettype none

module fe_ctrl_regfile
  import fe_ctrl_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [3:0] i_version,
  output logic      [7:0] o_rdata,
  output logic      [7:0] o_gain_delay,
  output logic      [7:0] o_input_select,
  output logic      [3:0] o_active_delay
);

  logic [7:0] gain_delay_q,   gain_delay_d;
  logic [7:0] input_select_q, input_select_d;
  logic [3:0] active_delay_q, active_delay_d;
  logic [7:0] rdata_q,        rdata_d;

  // ********************************************************************
  // Next values
  // ********************************************************************
  always_comb begin
    gain_delay_d   = gain_delay_q;
    input_select_d = input_select_q;
    active_delay_d = active_delay_q;
    // Version subaddress has no storage, so writes there fall away
    if (i_wr_en && i_addr == SUB_GAIN_DELAY) begin // R01
      gain_delay_d = i_wdata & GAIN_DELAY_MASK;
      if (i_wdata[DELAY_MSB:DELAY_LSB] != DELAY_NO_UPDATE) begin
        active_delay_d = i_wdata[DELAY_MSB:DELAY_LSB]; // R04
      end
    end
    if (i_wr_en && i_addr == SUB_INPUT_SELECT) begin
      input_select_d = i_wdata;
    end
    case (i_addr)
      SUB_SILICON_VERSION: rdata_d = {i_version, 4'h0}; // R01
      SUB_GAIN_DELAY:      rdata_d = gain_delay_q;
      SUB_INPUT_SELECT:    rdata_d = input_select_q;
      default:             rdata_d = UNMAPPED_READ;
    endcase
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      gain_delay_q   <= GAIN_DELAY_RESET;
      input_select_q <= INPUT_SELECT_RESET;
      active_delay_q <= GAIN_DELAY_RESET[DELAY_MSB:DELAY_LSB];
      rdata_q        <= UNMAPPED_READ;
    end else begin
      gain_delay_q   <= gain_delay_d;
      input_select_q <= input_select_d;
      active_delay_q <= active_delay_d;
      rdata_q        <= rdata_d;
    end
  end

  assign o_rdata        = rdata_q;
  assign o_gain_delay   = gain_delay_q;
  assign o_input_select = input_select_q;
  assign o_active_delay = active_delay_q;

endmodule

`default_nettype wire

//--- src/fe_ctrl_top.sv
// Purpose: Serial-bus slave and decoded controls of the analog front end.
// Assumes: SCL and SDA sampled synchronously, each level held >= 2 clocks.
// Notes:   Subaddress auto-increments after every data byte.
// Behaviour
// R01 - Subaddress 00h upper nibble is silicon version, read only.
// R02 - White peak disable 0 attenuates over-white signal, 1 turns it off.
// R03 - Two-bit gain update hysteresis: off, one, two or three LSB.
// R04 - Increment delay: 1110 minimum, 0000 maximum, 1111 no update.
// R05 - Host should program increment delay only with recommended value 0111; the bench also writes 0000, 1110, 0011 and 1111.
// R06 - Function select: 00/01 bypass, 10 amplifier, 11 amplifier and filter.
// R07 - Mode codes 0, 1, 2 pick composite input 11, 12, 21, auto gain.
// R08 - Host avoids horizontal noise reduction while white peak is active.
// R09 - Host writes zero into every unused control bit.
`timescale 1ns/1ps
`default_nettype none

module fe_ctrl_top
  import fe_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR        = DEV_ADDR_DEFAULT,
  // Arbitrary value, replace with the real silicon version
  parameter logic [3:0] SILICON_VERSION = SILICON_VERSION_DEFAULT
)
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe_n,
  output logic            o_white_peak_enable,
  output logic      [1:0] o_gain_update_hysteresis,
  output logic      [3:0] o_increment_delay,
  output logic      [3:0] o_processing_delay,
  output logic            o_amp_enable,
  output logic            o_aa_filter_enable,
  output logic      [5:0] o_input_mode,
  output logic            o_analog_input_eleven,
  output logic            o_analog_input_twelve,
  output logic            o_analog_input_twenty_one,
  output logic            o_cvbs_auto_gain
);

  // ********************************************************************
  // Line edges and bus conditions
  // ********************************************************************
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  assign scl_rise   = i_scl & ~scl_q;
  assign scl_fall   = ~i_scl & scl_q;
  assign start_cond = i_scl & scl_q & sda_q & ~i_sda;
  assign stop_cond  = i_scl & scl_q & ~sda_q & i_sda;

  // ********************************************************************
  // Serial slave state machine
  // ********************************************************************
  bus_state_t state_q, state_d;
  logic [2:0] cnt_q,   cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] sub_q,   sub_d;
  logic       done_q,  done_d;
  logic       rw_q,    rw_d;
  logic       drive_q, drive_d;
  logic       mack_q,  mack_d;
  logic       wr_en;
  logic [7:0] rdata;
  logic [7:0] gain_delay;
  logic [7:0] input_select;
  logic [3:0] active_delay;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    sub_d   = sub_q;
    done_d  = done_q;
    rw_d    = rw_q;
    drive_d = drive_q;
    mack_d  = mack_q;
    wr_en   = 1'b0;
    // A repeated start or a stop aborts whatever byte is in flight
    if (stop_cond) begin
      state_d = ST_IDLE;
      drive_d = 1'b0;
    end else if (start_cond) begin
      state_d = ST_ADDR;
      cnt_d   = 3'h0;
      done_d  = 1'b0;
      drive_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_SUB, ST_WDATA: begin
          if (scl_rise && !done_q) begin
            shift_d = {shift_q[6:0], i_sda};
            cnt_d   = cnt_q + 3'h1;
            done_d  = (cnt_q == LAST_BIT);
          end else if (scl_fall && done_q) begin
            done_d  = 1'b0;
            cnt_d   = 3'h0;
            drive_d = 1'b1;
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                rw_d    = shift_q[0];
                state_d = ST_ADDR_ACK;
              end else begin
                drive_d = 1'b0;
                state_d = ST_IDLE;
              end
            end else if (state_q == ST_SUB) begin
              sub_d   = shift_q;
              state_d = ST_SUB_ACK;
            end else begin
              wr_en   = 1'b1;
              state_d = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q == RW_READ) begin
              shift_d = rdata;
              drive_d = ~rdata[7];
              sub_d   = sub_q + 8'h01;
              cnt_d   = 3'h0;
              state_d = ST_RDATA;
            end else begin
              drive_d = 1'b0;
              state_d = ST_SUB;
            end
          end
        end
        ST_SUB_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            state_d = ST_WDATA;
            if (state_q == ST_WDATA_ACK) begin
              sub_d = sub_q + 8'h01;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise && !done_q) begin
            cnt_d  = cnt_q + 3'h1;
            done_d = (cnt_q == LAST_BIT);
          end else if (scl_fall) begin
            if (done_q) begin
              done_d  = 1'b0;
              drive_d = 1'b0;
              state_d = ST_RDATA_ACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              drive_d = ~shift_q[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            mack_d = ~i_sda;
          end else if (scl_fall) begin
            if (mack_q) begin
              shift_d = rdata;
              drive_d = ~rdata[7];
              sub_d   = sub_q + 8'h01;
              cnt_d   = 3'h0;
              state_d = ST_RDATA;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      shift_q <= 8'h00;
      sub_q   <= 8'h00;
      done_q  <= 1'b0;
      rw_q    <= 1'b0;
      drive_q <= 1'b0;
      mack_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      sub_q   <= sub_d;
      done_q  <= done_d;
      rw_q    <= rw_d;
      drive_q <= drive_d;
      mack_q  <= mack_d;
    end
  end

  // Open drain: the data line is only ever pulled low
  assign o_sda_out  = 1'b0;
  assign o_sda_oe_n = ~drive_q;

  // ********************************************************************
  // Register storage
  // ********************************************************************
  fe_ctrl_regfile fe_ctrl_regfile_inst (
    .i_clk          (i_clk),
    .i_reset        (i_reset),
    .i_wr_en        (wr_en),
    .i_addr         (sub_q),
    .i_wdata        (shift_q),
    .i_version      (SILICON_VERSION),
    .o_rdata        (rdata),
    .o_gain_delay   (gain_delay),
    .o_input_select (input_select),
    .o_active_delay (active_delay)
  );

  // ********************************************************************
  // Decoded front end controls
  // ********************************************************************
  logic       wpe_q,  wpe_d;
  logic [1:0] hyst_q, hyst_d;
  logic [3:0] incd_q, incd_d;
  logic [3:0] pdel_q, pdel_d;
  logic       amp_q,  amp_d;
  logic       aaf_q,  aaf_d;
  logic [5:0] mode_q, mode_d;
  logic [2:0] sel_q,  sel_d;
  logic       agc_q,  agc_d;
  logic [1:0] fsel;

  always_comb begin
    fsel   = input_select[FSEL_MSB:FSEL_LSB];
    wpe_d  = ~gain_delay[WPD_BIT]; // R02
    hyst_d = gain_delay[HYST_MSB:HYST_LSB]; // R03
    incd_d = active_delay; // R04
    // Steps above the minimum; a held 1111 never reaches here
    pdel_d = DELAY_MIN_CODE - active_delay; // R04
    amp_d  = (fsel == FSEL_AMP_ONLY) || (fsel == FSEL_AMP_FILTER); // R06
    aaf_d  = (fsel == FSEL_AMP_FILTER); // R06
    mode_d = input_select[MODE_MSB:MODE_LSB];
    sel_d  = {mode_d == MODE_CVBS_IN21,
              mode_d == MODE_CVBS_IN12,
              mode_d == MODE_CVBS_IN11}; // R07
    agc_d  = |sel_d; // R07
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wpe_q  <= 1'b1;
      hyst_q <= 2'h0;
      incd_q <= 4'h0;
      pdel_q <= 4'h0;
      amp_q  <= 1'b0;
      aaf_q  <= 1'b0;
      mode_q <= 6'h00;
      sel_q  <= 3'h0;
      agc_q  <= 1'b0;
    end else begin
      wpe_q  <= wpe_d;
      hyst_q <= hyst_d;
      incd_q <= incd_d;
      pdel_q <= pdel_d;
      amp_q  <= amp_d;
      aaf_q  <= aaf_d;
      mode_q <= mode_d;
      sel_q  <= sel_d;
      agc_q  <= agc_d;
    end
  end

  assign o_white_peak_enable       = wpe_q;
  assign o_gain_update_hysteresis  = hyst_q;
  assign o_increment_delay         = incd_q;
  assign o_processing_delay        = pdel_q;
  assign o_amp_enable              = amp_q;
  assign o_aa_filter_enable        = aaf_q;
  assign o_input_mode              = mode_q;
  assign o_analog_input_eleven     = sel_q[0];
  assign o_analog_input_twelve     = sel_q[1];
  assign o_analog_input_twenty_one = sel_q[2];
  assign o_cvbs_auto_gain          = agc_q;

endmodule

`default_nettype wire

//--- sim/fe_ctrl_top_monitor.sv
// Purpose: Port-level checks of the front end control block.
// Assumes: Decoded outputs follow the registers one clock late.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module fe_ctrl_top_monitor
  import fe_ctrl_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe_n,
  input wire logic       o_white_peak_enable,
  input wire logic [1:0] o_gain_update_hysteresis,
  input wire logic [3:0] o_increment_delay,
  input wire logic [3:0] o_processing_delay,
  input wire logic       o_amp_enable,
  input wire logic       o_aa_filter_enable,
  input wire logic [5:0] o_input_mode,
  input wire logic       o_analog_input_eleven,
  input wire logic       o_analog_input_twelve,
  input wire logic       o_analog_input_twenty_one,
  input wire logic       o_cvbs_auto_gain
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ********
  // Checks
  // ********
  a_filter_amp: assert property (
    o_aa_filter_enable |-> o_amp_enable)
    else $error("filter enabled without amplifier");
  a_auto_gain_any: assert property (
    o_cvbs_auto_gain == (o_analog_input_eleven | o_analog_input_twelve |
                         o_analog_input_twenty_one))
    else $error("auto gain flag disagrees with input flags");
  // Reset shows all input decodes low, so the first edge after it is skipped
  a_input_eleven: assert property (
    !$past(i_reset) |->
      o_analog_input_eleven == (o_input_mode == MODE_CVBS_IN11))
    else $error("input eleven decode wrong");
  a_input_twelve: assert property (
    o_analog_input_twelve == (o_input_mode == MODE_CVBS_IN12))
    else $error("input twelve decode wrong");
  a_input_twenty_one: assert property (
    o_analog_input_twenty_one == (o_input_mode == MODE_CVBS_IN21))
    else $error("input twenty one decode wrong");
  a_delay_scale: assert property (
    !$past(i_reset) |->
      o_processing_delay == DELAY_MIN_CODE - o_increment_delay)
    else $error("processing delay not derived from code");
  a_delay_kept: assert property (
    o_increment_delay != DELAY_NO_UPDATE)
    else $error("no update code became active");
  a_reset_defaults: assert property (
    $fell(i_reset) |=> o_white_peak_enable &&
      o_increment_delay == GAIN_DELAY_RESET[3:0])
    else $error("reset defaults not shown");
  // SDA may only move while SCL is low, else a start or stop is faked
  a_sda_scl_low: assert property (
    $changed(o_sda_oe_n) |-> !i_scl)
    else $error("data line moved while clock high");
  a_sda_drive_low: assert property (
    o_sda_out == 1'b0)
    else $error("open drain value not low");

  c_ack: cover property (!o_sda_oe_n);
  c_filter: cover property (o_aa_filter_enable);
  c_input_21: cover property (o_analog_input_twenty_one);
endmodule

bind fe_ctrl_top fe_ctrl_top_monitor fe_ctrl_top_monitor_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
  .o_white_peak_enable(o_white_peak_enable),
  .o_gain_update_hysteresis(o_gain_update_hysteresis),
  .o_increment_delay(o_increment_delay),
  .o_processing_delay(o_processing_delay),
  .o_amp_enable(o_amp_enable), .o_aa_filter_enable(o_aa_filter_enable),
  .o_input_mode(o_input_mode),
  .o_analog_input_eleven(o_analog_input_eleven),
  .o_analog_input_twelve(o_analog_input_twelve),
  .o_analog_input_twenty_one(o_analog_input_twenty_one),
  .o_cvbs_auto_gain(o_cvbs_auto_gain));

`default_nettype wire

//--- sim/fe_host_model.sv
// Purpose: Serial-bus host controller that programs the block.
// Assumes: Each line level held five clocks, above the two-clock minimum.
// Notes:   SDA output 1 releases the line; the pull-up is in the bench.
`timescale 1ns/1ps
`default_nettype none

module fe_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // ********
  // Line steps
  // ********
  // SCL moves first and SDA a clock later, so no edge is ever shared
  task automatic cyc(input logic s, input logic d);
    @(negedge i_clk);
    o_scl = s;
    @(negedge i_clk);
    o_sda = d;
    repeat (3) @(negedge i_clk);
  endtask

  task automatic start();
    cyc(1'b0, 1'b1);
    cyc(1'b1, 1'b1);
    cyc(1'b1, 1'b0);
  endtask

  task automatic stop();
    cyc(1'b0, 1'b0);
    cyc(1'b1, 1'b0);
    cyc(1'b1, 1'b1);
  endtask

  // Eight data bits and the acknowledge slot, sampled late in SCL high
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      cyc(1'b0, tx[i]);
      cyc(1'b1, tx[i]);
      rx[i] = i_sda;
    end
  endtask
endmodule

`default_nettype wire

//--- sim/fe_ctrl_top_tb.sv
// Purpose: Self-checking bench of the front end control block.
// Assumes: Host model drives the bus; SDA has a pull-up.
// Notes: Host writes keep unused bits zero.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  errors++; $display("BAD %s exp %h got %h", n, e, g); end end

module fe_ctrl_top_tb
  import fe_ctrl_pkg::*;
;
  logic       clk;
  logic       reset;
  logic       scl;
  logic       host_sda;
  logic       sda_out;
  logic       sda_oe_n;
  logic       wpe;
  logic [1:0] hyst;
  logic [3:0] inc;
  logic [3:0] pdel;
  logic       amp;
  logic       aaf;
  logic [5:0] mode;
  logic       analog_input_eleven;
  logic       analog_input_twelve;
  logic       analog_input_twenty_one;
  logic       agc;
  logic [7:0] d;
  logic [7:0] v;
  logic [7:0] d2;
  logic [8:0] rx;
  logic [3:0] codes [4] = '{4'h0, DELAY_MIN_CODE, 4'h7, 4'h3};
  int         errors;
  int         checked;
  wire        sda_line = host_sda & (sda_oe_n | sda_out);

  fe_ctrl_top fe_ctrl_top_inst (
    .i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda_line),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .o_white_peak_enable(wpe), .o_gain_update_hysteresis(hyst),
    .o_increment_delay(inc), .o_processing_delay(pdel),
    .o_amp_enable(amp), .o_aa_filter_enable(aaf), .o_input_mode(mode),
    .o_analog_input_eleven(analog_input_eleven), .o_analog_input_twelve(analog_input_twelve),
    .o_analog_input_twenty_one(analog_input_twenty_one), .o_cvbs_auto_gain(agc));

  fe_host_model fe_host_model_inst (
    .i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ********
  // Bus tasks
  // ********
  task automatic wr_reg(input logic [7:0] sub, input logic [7:0] dat);
    fe_host_model_inst.start();
    fe_host_model_inst.bits({DEV_ADDR_DEFAULT, 1'b0, 1'b1}, rx);
    fe_host_model_inst.bits({sub, 1'b1}, rx);
    fe_host_model_inst.bits({dat, 1'b1}, rx);
    `CHK("write ack", 1'b0, rx[0])
    fe_host_model_inst.stop();
    repeat (4) @(negedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] sub, output logic [7:0] dat);
    fe_host_model_inst.start();
    fe_host_model_inst.bits({DEV_ADDR_DEFAULT, 1'b0, 1'b1}, rx);
    fe_host_model_inst.bits({sub, 1'b1}, rx);
    fe_host_model_inst.start();
    fe_host_model_inst.bits({DEV_ADDR_DEFAULT, RW_READ, 1'b1}, rx);
    fe_host_model_inst.bits(9'h1ff, rx);
    fe_host_model_inst.stop();
    dat = rx[8:1];
  endtask

  // Two bytes in one transfer, so the pointer steps between them
  task automatic wr_pair(input logic [7:0] sub, input logic [7:0] d0,
                         input logic [7:0] d1);
    fe_host_model_inst.start();
    fe_host_model_inst.bits({DEV_ADDR_DEFAULT, 1'b0, 1'b1}, rx);
    fe_host_model_inst.bits({sub, 1'b1}, rx);
    fe_host_model_inst.bits({d0, 1'b1}, rx);
    fe_host_model_inst.bits({d1, 1'b1}, rx);
    `CHK("burst ack", 1'b0, rx[0])
    fe_host_model_inst.stop();
    repeat (4) @(negedge clk);
  endtask

  // Host acknowledges the first byte and refuses the second
  task automatic rd_pair(input logic [7:0] sub, output logic [7:0] d0,
                         output logic [7:0] d1);
    fe_host_model_inst.start();
    fe_host_model_inst.bits({DEV_ADDR_DEFAULT, 1'b0, 1'b1}, rx);
    fe_host_model_inst.bits({sub, 1'b1}, rx);
    fe_host_model_inst.start();
    fe_host_model_inst.bits({DEV_ADDR_DEFAULT, RW_READ, 1'b1}, rx);
    fe_host_model_inst.bits(9'h1fe, rx);
    d0 = rx[8:1];
    fe_host_model_inst.bits(9'h1ff, rx);
    fe_host_model_inst.stop();
    d1 = rx[8:1];
  endtask

  task automatic chk01(input logic [7:0] r, input logic [3:0] act);
    `CHK("white peak", ~r[6], wpe)
    `CHK("hysteresis", r[5:4], hyst)
    `CHK("delay code", act, inc)
    `CHK("proc delay", DELAY_MIN_CODE - act, pdel)
  endtask

  task automatic chk02(input logic [7:0] r);
    `CHK("amplifier", r[7], amp)
    `CHK("filter", &r[7:6], aaf)
    `CHK("mode", r[5:0], mode)
    `CHK("input 11", r[5:0] == 6'h00, analog_input_eleven)
    `CHK("input 12", r[5:0] == 6'h01, analog_input_twelve)
    `CHK("input 21", r[5:0] == 6'h02, analog_input_twenty_one)
    `CHK("auto gain", r[5:0] < 6'h03, agc)
  endtask

  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    errors = 0;
    checked = 0;
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    chk01(GAIN_DELAY_RESET, GAIN_DELAY_RESET[3:0]);
    chk02(INPUT_SELECT_RESET);
    rd_reg(SUB_GAIN_DELAY, d);
    `CHK("read 01h", GAIN_DELAY_RESET, d)
    rd_reg(SUB_SILICON_VERSION, d);
    `CHK("version", SILICON_VERSION_DEFAULT, d[7:4])
    $display("test reset done");
    // Attempt to overwrite the version with its inverse
    wr_reg(SUB_SILICON_VERSION, {~SILICON_VERSION_DEFAULT, 4'h0});
    rd_reg(SUB_SILICON_VERSION, d);
    `CHK("version kept", SILICON_VERSION_DEFAULT, d[7:4])
    $display("test version done");
    // Noise reduction is never switched on by this host
    for (int h = 0; h < 4; h++) begin
      v = {1'b0, h[0], h[1:0], codes[h]};
      wr_reg(SUB_GAIN_DELAY, v);
      chk01(v, v[3:0]);
    end
    wr_reg(SUB_GAIN_DELAY, {4'h0, DELAY_NO_UPDATE});
    chk01({4'h0, DELAY_NO_UPDATE}, codes[3]);
    rd_reg(SUB_GAIN_DELAY, d);
    `CHK("read 0fh", {4'h0, DELAY_NO_UPDATE}, d)
    wr_reg(SUB_GAIN_DELAY, 8'h07);
    chk01(8'h07, 4'h7);
    $display("test gain done");
    for (int f = 0; f < 4; f++) begin
      for (int m = 0; m < 4; m++) begin
        v = {f[1:0], m[5:0]};
        wr_reg(SUB_INPUT_SELECT, v);
        chk02(v);
      end
    end
    rd_reg(SUB_INPUT_SELECT, d);
    `CHK("read 02h", v, d)
    $display("test select done");
    // Burst write and read walk the pointer from 01h on to 02h
    wr_pair(SUB_GAIN_DELAY, 8'h37, 8'h82);
    chk01(8'h37, 4'h7);
    chk02(8'h82);
    rd_pair(SUB_GAIN_DELAY, d, d2);
    `CHK("burst 01h", 8'h37, d)
    `CHK("burst 02h", 8'h82, d2)
    $display("test burst done");
    rd_reg(8'h10, d);
    `CHK("unmapped", UNMAPPED_READ, d)
    fe_host_model_inst.start();
    fe_host_model_inst.bits({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0, 1'b1}, rx);
    `CHK("foreign ack", 1'b1, rx[0])
    fe_host_model_inst.stop();
    $display("test refuse done");
    end_of_test();
  end

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
